// >>> inc/rscr_pkg.sv
package rscr_pkg;

    // Widths and depth defaults
    localparam int PC_W = 21;
    localparam int STACK_DEPTH = 31;
    localparam int OFFSET_W = 11;

    // Opcodes handled by this block
    localparam logic [15:0] OP_POP = 16'h0006;
    localparam logic [15:0] OP_PUSH = 16'h0005;
    localparam logic [15:0] OP_SOFT_RESET = 16'h00ff;
    localparam logic [15:0] CALL_MASK = 16'hf800;
    localparam logic [15:0] CALL_MATCH = 16'hd800;

    // Values after reset and address step
    localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    localparam logic [PC_W-1:0] TOP_RESET = 21'h000000;

    // Quarters of one instruction cycle, one clock each
    typedef enum logic [3:0] {
        RSCR_Q1 = 4'h1,
        RSCR_Q2 = 4'h2,
        RSCR_Q3 = 4'h4,
        RSCR_Q4 = 4'h8
    } rscr_quarter_t;

    // Kind of instruction in flight
    typedef enum logic [5:0] {
        RSCR_K_IDLE = 6'h01,
        RSCR_K_OTHER = 6'h02,
        RSCR_K_POP = 6'h04,
        RSCR_K_PUSH = 6'h08,
        RSCR_K_CALL = 6'h10,
        RSCR_K_RESET = 6'h20
    } rscr_kind_t;

endpackage : rscr_pkg

// >>> inc/rscr_stack_if.sv
`timescale 1ns/1ps
interface rscr_stack_if #(
    parameter int W = 21,
    parameter int LW = 5
) ();
    logic push;
    logic pop;
    logic clear;
    logic [W-1:0] push_data;
    logic [W-1:0] top;
    logic [LW-1:0] level;

    modport exec (output push, output pop, output clear, output push_data,
                  input top, input level);
    modport stack (input push, input pop, input clear, input push_data,
                   output top, output level);
endinterface : rscr_stack_if

// >>> src/rscr_return_stack.sv
`timescale 1ns/1ps
module rscr_return_stack #(
    parameter int DEPTH = rscr_pkg::STACK_DEPTH,
    parameter int W = rscr_pkg::PC_W,
    parameter int LW = $clog2(DEPTH + 1)
) (
    input wire logic clk_i,
    input wire logic rst_i,
    rscr_stack_if.stack sif
);
    logic [W-1:0] top_q;
    logic [LW-1:0] level_q;
    logic [W-1:0] mem_q [DEPTH-1];

    // Top kept in its own flop so the output needs no read mux
    wire [LW-1:0] below_idx = level_q - LW'(1);
    wire [LW-1:0] pop_idx = level_q - LW'(2);
    wire can_push = sif.push && (level_q != LW'(DEPTH));
    wire can_pop = sif.pop && (level_q != LW'(0));
    wire [W-1:0] next_down = (level_q > LW'(1)) ? mem_q[pop_idx] : rscr_pkg::TOP_RESET;

    // Overflow and underflow are ignored; a push when full or a pop when empty changes nothing
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            top_q <= rscr_pkg::TOP_RESET;
            level_q <= '0;
        end else if (sif.clear) begin
            top_q <= rscr_pkg::TOP_RESET;
            level_q <= '0;
        end else if (can_push) begin
            top_q <= sif.push_data;
            level_q <= level_q + LW'(1);
        end else if (can_pop) begin
            top_q <= next_down;
            level_q <= level_q - LW'(1);
        end
    end

    // Entries below the top are data only, no reset needed
    always_ff @(posedge clk_i) begin
        if (can_push && !sif.clear && (level_q != LW'(0))) begin
            mem_q[below_idx] <= top_q;
        end
    end

    assign sif.top = top_q;
    assign sif.level = level_q;

endmodule : rscr_return_stack

// >>> src/rscr_exec.sv
`timescale 1ns/1ps
module rscr_exec #(
    parameter int PC_W = rscr_pkg::PC_W,
    parameter int DEPTH = rscr_pkg::STACK_DEPTH,
    parameter int LW = $clog2(DEPTH + 1)
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [15:0] instr_i,
    input wire logic instr_valid_i,
    output logic [PC_W-1:0] program_counter_o,
    output logic [PC_W-1:0] top_of_stack_entry_o,
    output logic [LW-1:0] stack_level_o,
    output logic decode_phase_o,
    output logic refill_o,
    output logic soft_reset_o
);
    rscr_stack_if #(.W(PC_W), .LW(LW)) sif ();

    rscr_return_stack #(
        .DEPTH(DEPTH),
        .W(PC_W),
        .LW(LW)
    ) u_stack (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sif(sif)
    );

    rscr_pkg::rscr_quarter_t st_q;
    rscr_pkg::rscr_quarter_t st_d;
    rscr_pkg::rscr_kind_t kind_q;
    rscr_pkg::rscr_kind_t kind_d;
    rscr_pkg::rscr_kind_t dec_kind;
    logic [PC_W-1:0] pc_q;
    logic [PC_W-1:0] pc_d;
    logic [rscr_pkg::OFFSET_W-1:0] offs_q;
    logic refill_q;
    logic refill_d;
    logic soft_q;

    // Opcode decode
    wire is_pop = (instr_i == rscr_pkg::OP_POP);
    wire is_push = (instr_i == rscr_pkg::OP_PUSH);
    wire is_call = ((instr_i & rscr_pkg::CALL_MASK) == rscr_pkg::CALL_MATCH);
    wire is_rst = (instr_i == rscr_pkg::OP_SOFT_RESET);
    assign dec_kind = is_pop ? rscr_pkg::RSCR_K_POP :
                      is_push ? rscr_pkg::RSCR_K_PUSH :
                      is_call ? rscr_pkg::RSCR_K_CALL :
                      is_rst ? rscr_pkg::RSCR_K_RESET : rscr_pkg::RSCR_K_OTHER;

    // Instructions are only taken in the decode quarter and never while refilling
    wire in_q1 = (st_q == rscr_pkg::RSCR_Q1);
    wire in_q2 = (st_q == rscr_pkg::RSCR_Q2);
    wire in_q3 = (st_q == rscr_pkg::RSCR_Q3);
    wire in_q4 = (st_q == rscr_pkg::RSCR_Q4);
    wire take = in_q1 && instr_valid_i && !refill_q;

    // Stack strobes per quarter
    wire k_call = (kind_q == rscr_pkg::RSCR_K_CALL);
    wire do_push = in_q2 && (k_call || (kind_q == rscr_pkg::RSCR_K_PUSH));
    wire do_pop = in_q3 && (kind_q == rscr_pkg::RSCR_K_POP);
    wire do_soft = in_q2 && (kind_q == rscr_pkg::RSCR_K_RESET);

    // Return address and call target; offset is sign extended and doubled
    wire [PC_W-1:0] pc_inc = pc_q + rscr_pkg::PC_STEP;
    wire [PC_W-1:0] offs_x2 = {{(PC_W-rscr_pkg::OFFSET_W-1){offs_q[rscr_pkg::OFFSET_W-1]}},
                               offs_q, 1'b0};
    wire [PC_W-1:0] call_target = pc_inc + offs_x2;
    wire pc_write = in_q4 && (kind_q != rscr_pkg::RSCR_K_IDLE);

    assign sif.push = do_push;
    assign sif.pop = do_pop;
    assign sif.clear = do_soft;
    assign sif.push_data = pc_inc;

    // Next quarter; soft reset drops back to decode at once
    assign st_d = do_soft ? rscr_pkg::RSCR_Q1 :
                  in_q1 ? rscr_pkg::RSCR_Q2 :
                  in_q2 ? rscr_pkg::RSCR_Q3 :
                  in_q3 ? rscr_pkg::RSCR_Q4 : rscr_pkg::RSCR_Q1;

    // Kind is latched at decode and held for the whole instruction cycle
    assign kind_d = do_soft ? rscr_pkg::RSCR_K_IDLE :
                    in_q1 ? (take ? dec_kind : rscr_pkg::RSCR_K_IDLE) : kind_q;

    // Program counter written in the last quarter, so the push sees the old value
    assign pc_d = do_soft ? rscr_pkg::PC_RESET :
                  (pc_write && k_call) ? call_target :
                  pc_write ? pc_inc : pc_q;

    // One idle instruction cycle follows a call while fetch refills
    assign refill_d = do_soft ? 1'b0 :
                      in_q4 ? (pc_write && k_call) : refill_q;

    // Sequencer state
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= rscr_pkg::RSCR_Q1;
            kind_q <= rscr_pkg::RSCR_K_IDLE;
        end else begin
            st_q <= st_d;
            kind_q <= kind_d;
        end
    end

    // Program counter, refill flag and soft reset pulse
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pc_q <= rscr_pkg::PC_RESET;
            refill_q <= 1'b0;
            soft_q <= 1'b0;
        end else begin
            pc_q <= pc_d;
            refill_q <= refill_d;
            soft_q <= do_soft;
        end
    end

    // Offset field captured with the opcode
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            offs_q <= '0;
        end else if (do_soft) begin
            offs_q <= '0;
        end else if (take) begin
            offs_q <= instr_i[rscr_pkg::OFFSET_W-1:0];
        end
    end

    assign program_counter_o = pc_q;
    assign top_of_stack_entry_o = sif.top;
    assign stack_level_o = sif.level;
    assign decode_phase_o = st_q[0];
    assign refill_o = refill_q;
    assign soft_reset_o = soft_q;

    // Helpers for the checks below
    wire [PC_W-1:0] off_now_x2 = {{(PC_W-rscr_pkg::OFFSET_W-1){instr_i[rscr_pkg::OFFSET_W-1]}},
                                  instr_i[rscr_pkg::OFFSET_W-1:0], 1'b0};
    wire [PC_W-1:0] target_now = pc_q + rscr_pkg::PC_STEP + off_now_x2;
    wire room = (sif.level != LW'(DEPTH));
    wire deep = (sif.level > LW'(1));
    // Smallest jump distance a backward call can show once wrapped to the address width
    wire [PC_W-1:0] back_floor = {{(PC_W-rscr_pkg::OFFSET_W){1'b1}}, {rscr_pkg::OFFSET_W{1'b0}}};

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    AST_POP_DROPS_TOP: assert property (
        take && is_pop && deep |-> ##3 (sif.level == $past(sif.level, 3) - LW'(1))
    ) else $error("pop did not remove exactly one entry");

    AST_PUSH_NEXT_ADDR: assert property (
        take && is_push && room |-> ##2 (sif.top == $past(pc_q, 2) + rscr_pkg::PC_STEP)
            ##0 (sif.level == $past(sif.level, 2) + LW'(1))
    ) else $error("push did not store address plus two");

    AST_PUSH_OLD_DOWN: assert property (
        take && is_push && room && (sif.level != LW'(0)) |->
            ##2 (u_stack.mem_q[$past(sif.level, 2) - LW'(1)] == $past(sif.top, 2))
    ) else $error("push did not move the old top one level down");

    AST_CALL_RETURN_ADDR: assert property (
        take && is_call && room |-> ##2 (sif.top == $past(pc_q, 2) + rscr_pkg::PC_STEP)
            ##0 (pc_q == $past(pc_q, 2))
    ) else $error("call return address wrong or pushed after jump");

    AST_CALL_TARGET: assert property (
        take && is_call |-> ##4 (pc_q == $past(target_now, 4))
    ) else $error("call target wrong");

    AST_CALL_IDLE_CYCLE: assert property (
        take && is_call |-> ##4 refill_q [*4] ##1 !refill_q
    ) else $error("call refill cycle not exactly one instruction cycle");

    AST_OFFSET_RANGE: assert property (
        take && is_call && instr_i[10] |->
            ##4 ((pc_q - $past(pc_q, 4) - rscr_pkg::PC_STEP) >= back_floor)
    ) else $error("negative offset not sign extended");

    AST_SOFT_CLEARS: assert property (
        soft_q |-> (pc_q == rscr_pkg::PC_RESET) && (sif.level == LW'(0)) && in_q1
            && !refill_q && (kind_q == rscr_pkg::RSCR_K_IDLE)
    ) else $error("soft reset left state behind");

    AST_SOFT_IN_Q2: assert property (
        take && is_rst |=> in_q2 && !soft_q
            ##1 soft_q && in_q1 && (pc_q == rscr_pkg::PC_RESET) ##1 !soft_q
    ) else $error("soft reset not started in second quarter");

    COV_POP: cover property (take && is_pop && deep);
    COV_PUSH: cover property (take && is_push);
    COV_CALL: cover property (take && is_call ##4 refill_q);
    COV_SOFT: cover property (take && is_rst ##1 soft_q);

endmodule : rscr_exec

// >>> verif/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic clk_i;
    logic rst_i;
    logic [15:0] instr_i;
    logic instr_valid_i;
    logic [20:0] program_counter_o;
    logic [20:0] top_of_stack_entry_o;
    logic [4:0] stack_level_o;
    logic decode_phase_o;
    logic refill_o;
    logic soft_reset_o;
    int err_count;
    int tests_run;
    int seed_dummy;
    // Reference model: flat address plus a queue for the return stack
    logic [20:0] m_pc;
    logic [20:0] m_stk[$];
    logic [10:0] offs[4] = '{11'h400, 11'h3ff, 11'h000, 11'h7ff};

    rscr_exec uut (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .instr_i(instr_i),
        .instr_valid_i(instr_valid_i),
        .program_counter_o(program_counter_o),
        .top_of_stack_entry_o(top_of_stack_entry_o),
        .stack_level_o(stack_level_o),
        .decode_phase_o(decode_phase_o),
        .refill_o(refill_o),
        .soft_reset_o(soft_reset_o)
    );

    // Free running bench clock, 100 ns period
    always #50 clk_i = ~clk_i;

    task complete_run();
        if (err_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    task check(input string what, input logic [20:0] seen, input logic [20:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Compares the visible state with the model once an instruction has run
    task check_state(input logic exp_refill);
        check("pc", program_counter_o, m_pc);
        check("top", top_of_stack_entry_o, (m_stk.size() > 0) ? m_stk[$] : 21'h000000);
        check("level", {16'h0000, stack_level_o}, 21'(m_stk.size()));
        check("refill", {20'h00000, refill_o}, {20'h00000, exp_refill});
    endtask : check_state

    // Waits for a decode quarter, offering a stray push meanwhile that must be ignored
    task run(input logic [15:0] op, input logic v);
        int n;
        n = 0;
        while (!(decode_phase_o === 1'b1 && refill_o === 1'b0)) begin
            instr_i = rscr_pkg::OP_PUSH;
            instr_valid_i = 1'b1;
            n++;
            if (n > 20) begin
                err_count++;
                complete_run();
            end
            @(negedge clk_i);
        end
        instr_i = op;
        instr_valid_i = v;
        @(negedge clk_i);
        instr_valid_i = 1'b0;
        if (v && op == rscr_pkg::OP_SOFT_RESET) begin
            m_pc = 21'h000000;
            m_stk.delete();
            @(negedge clk_i);
            check("soft_reset", {20'h00000, soft_reset_o}, 21'h000001);
            check("decode", {20'h00000, decode_phase_o}, 21'h000001);
            check_state(1'b0);
            return;
        end
        if (v && op == rscr_pkg::OP_POP) begin
            if (m_stk.size() > 0) void'(m_stk.pop_back());
            m_pc = m_pc + 21'h000002;
        end else if (v && op == rscr_pkg::OP_PUSH) begin
            if (m_stk.size() < 31) m_stk.push_back(m_pc + 21'h000002);
            m_pc = m_pc + 21'h000002;
        end else if (v && (op & rscr_pkg::CALL_MASK) == rscr_pkg::CALL_MATCH) begin
            if (m_stk.size() < 31) m_stk.push_back(m_pc + 21'h000002);
            m_pc = m_pc + 21'h000002 + {{9{op[10]}}, op[10:0], 1'b0};
        end else if (v) begin
            m_pc = m_pc + 21'h000002;
        end
        repeat (3) @(negedge clk_i);
        check_state(v && (op & rscr_pkg::CALL_MASK) == rscr_pkg::CALL_MATCH);
        check("soft_reset", {20'h00000, soft_reset_o}, 21'h000000);
    endtask : run

    // Main sequence: reset, stack traffic, calls, overflow, soft reset
    initial begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        instr_i = 16'h0000;
        instr_valid_i = 1'b0;
        err_count = 0;
        tests_run = 0;
        m_pc = 21'h000000;
        seed_dummy = $urandom(3);
        repeat (4) @(negedge clk_i);
        rst_i = 1'b0;
        check_state(1'b0);
        run(rscr_pkg::OP_POP, 1'b1);
        for (int i = 0; i < 3; i++) run(rscr_pkg::OP_PUSH, 1'b1);
        run(rscr_pkg::OP_POP, 1'b1);
        run(rscr_pkg::OP_PUSH, 1'b0);
        // Boundary offsets first, then random ones, each followed by another opcode
        for (int i = 0; i < 10; i++) begin
            run({5'h1b, (i < 4) ? offs[i] : 11'($urandom)}, 1'b1);
            run({4'h1, 12'($urandom)}, 1'b1);
        end
        for (int i = 0; i < 26; i++) run(rscr_pkg::OP_PUSH, 1'b1);
        run(rscr_pkg::OP_SOFT_RESET, 1'b1);
        run(rscr_pkg::OP_PUSH, 1'b1);
        run({5'h1b, 11'h001}, 1'b1);
        for (int i = 0; i < 3; i++) run(rscr_pkg::OP_POP, 1'b1);
        // Pin reset in mid-run must leave the same state as the soft reset
        rst_i = 1'b1;
        @(negedge clk_i);
        rst_i = 1'b0;
        m_pc = 21'h000000;
        m_stk.delete();
        check_state(1'b0);
        run(rscr_pkg::OP_PUSH, 1'b1);
        complete_run();
    end
endmodule : testbench
